// [otgpc_regs.svh]
// register offsets, field positions, reset values and timing counts of the otg port control block
`ifndef OTGPC_REGS_SVH
`define OTGPC_REGS_SVH

// ****************************************************************
// register offsets (16-bit word registers, byte address)
// ****************************************************************
`define OTGPC_CTRL_ADDR      16'hc098
`define OTGPC_INT_STS_ADDR   16'hc09a
`define OTGPC_INT_CLR_ADDR   16'hc09c
`define OTGPC_INT_EN_ADDR    16'hc09e

// ****************************************************************
// control register fields
// ****************************************************************
`define OTGPC_VBUS_PU_BIT    13
`define OTGPC_RX_DIS_BIT     12
`define OTGPC_CHG_PUMP_BIT   11
`define OTGPC_VBUS_DIS_BIT   10
`define OTGPC_DP_PU_BIT      9
`define OTGPC_DM_PU_BIT      8
`define OTGPC_DP_PD_BIT      7
`define OTGPC_DM_PD_BIT      6
`define OTGPC_VBUS_LVL_BIT   2
`define OTGPC_ID_BIT         1
`define OTGPC_VBUS_VLD_BIT   0
`define OTGPC_CTRL_RW_MASK   16'h3fc0
`define OTGPC_CTRL_RESET     16'h0000

// ****************************************************************
// interrupt fields
// ****************************************************************
`define OTGPC_EVT_VBUS_LVL   0
`define OTGPC_EVT_ID         1
`define OTGPC_EVT_VBUS_VLD   2
`define OTGPC_EVT_SETTLE     3
`define OTGPC_INT_EN_RESET   4'h0
`define OTGPC_INT_STS_RESET  4'h0

// ****************************************************************
// timing
// ****************************************************************
`define OTGPC_CLK_PERIOD_NS  4
`define OTGPC_SETTLE_NS      10000
`define OTGPC_SETTLE_CYCLES  ((`OTGPC_SETTLE_NS + `OTGPC_CLK_PERIOD_NS - 1) / `OTGPC_CLK_PERIOD_NS)
`define OTGPC_PRIME_CYCLES   2'h3

`endif

// [otgpc_pkg.sv]
// types shared by the otg port control block
package otgpc_pkg;

   typedef logic [15:0] otgpc_addr_t;
   typedef logic [15:0] otgpc_word_t;
   typedef logic [3:0]  otgpc_evt_t;
   typedef logic [2:0]  otgpc_pins_t;

   typedef enum logic [1:0] {
      OTGPC_SETTLE_IDLE,
      OTGPC_SETTLE_RUN,
      OTGPC_SETTLE_DONE
   } otgpc_settle_t;

endpackage : otgpc_pkg

// [otgpc_sync.sv]
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps

module otgpc_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // ****************************************************************
   // synchroniser stages
   // ****************************************************************
   // first stage is read only by the second stage
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;

endmodule : otgpc_sync

// [otgpc_top.sv]
// control and status register of the dual-role usb port with interrupt and settle timer
// Function
// - control bit 13 switches the 500 ohm vbus pull-up on or off.
// - control bit 12 powers down the port receiver when set.
// - control bit 11 turns the vbus charge pump on or off.
// - control bit 10 attaches the 2k-ohm vbus discharge pull-down.
// - control bit 9 enables the d+ pull-up.
// - control bit 8 enables the d- pull-up.
// - control bit 7 enables the d+ pull-down.
// - control bit 6 enables the d- pull-down.
// - read-only bit 2 returns the vbus logic level.
// - read-only bit 1 returns the id pin state, one when not grounded.
// - read-only bit 0 returns vbus valid, above 4.4v.
`timescale 1ns/1ps
`include "otgpc_regs.svh"

module otgpc_top #(
   parameter int unsigned SETTLE_CYCLES = `OTGPC_SETTLE_CYCLES
) (
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   input  wire otgpc_pkg::otgpc_addr_t addr_i,
   input  wire otgpc_pkg::otgpc_word_t wr_data_i,
   input  wire logic                   wr_en_i,
   input  wire logic                   rd_en_i,
   output otgpc_pkg::otgpc_word_t      rd_data_o,
   input  wire logic                   vbus_level_i,
   input  wire logic                   id_pin_i,
   input  wire logic                   vbus_valid_i,
   output logic                        vbus_pullup_en_o,
   output logic                        rx_pwrdn_o,
   output logic                        chg_pump_en_o,
   output logic                        vbus_dischg_en_o,
   output logic                        dp_pullup_en_o,
   output logic                        dm_pullup_en_o,
   output logic                        dp_pulldown_en_o,
   output logic                        dm_pulldown_en_o,
   output logic                        irq_o
);
   import otgpc_pkg::*;

   localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

   otgpc_word_t   ctrl_r;
   otgpc_word_t   ctrl_nxt;
   otgpc_word_t   rd_data_r;
   otgpc_word_t   rd_data_nxt;
   otgpc_evt_t    int_sts_r;
   otgpc_evt_t    int_sts_nxt;
   otgpc_evt_t    int_en_r;
   otgpc_evt_t    int_clr;
   otgpc_evt_t    evt;
   otgpc_pins_t   pins_async;
   otgpc_pins_t   pins_s;
   otgpc_pins_t   pins_prev_r;
   logic [1:0]    prime_cnt_r;
   logic          primed;
   logic          irq_r;
   logic          pump_prev_r;
   logic          pump_rise;
   logic          settle_evt;
   logic [15:0]   settle_cnt_r;
   otgpc_settle_t settle_r;
   otgpc_settle_t settle_nxt;
   logic          wr_ctrl;
   logic          wr_clr;
   logic          wr_en;

   // ****************************************************************
   // address decode helper
   // ****************************************************************
   function automatic logic hit(input otgpc_addr_t a, input otgpc_addr_t target);
      hit = (a == target);
   endfunction : hit

   function automatic otgpc_word_t read_mux(input otgpc_addr_t a,
                                            input otgpc_word_t ctrl,
                                            input otgpc_pins_t pins,
                                            input otgpc_evt_t  sts,
                                            input otgpc_evt_t  en);
      otgpc_word_t v;
      v = 16'h0000;
      if (hit(a, `OTGPC_CTRL_ADDR)) begin
         v = ctrl & `OTGPC_CTRL_RW_MASK;
         v[`OTGPC_VBUS_LVL_BIT] = pins[`OTGPC_VBUS_LVL_BIT];
         v[`OTGPC_ID_BIT]       = pins[`OTGPC_ID_BIT];
         v[`OTGPC_VBUS_VLD_BIT] = pins[`OTGPC_VBUS_VLD_BIT];
      end else if (hit(a, `OTGPC_INT_STS_ADDR)) begin
         v = {12'h000, sts};
      end else if (hit(a, `OTGPC_INT_EN_ADDR)) begin
         v = {12'h000, en};
      end
      read_mux = v;
   endfunction : read_mux

   // ****************************************************************
   // status input synchronisation
   // ****************************************************************
   assign pins_async[`OTGPC_VBUS_LVL_BIT] = vbus_level_i;
   assign pins_async[`OTGPC_ID_BIT]       = id_pin_i;
   assign pins_async[`OTGPC_VBUS_VLD_BIT] = vbus_valid_i;

   otgpc_sync #(
      .WIDTH (3)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (pins_async),
      .sync_o    (pins_s)
   );

   // ****************************************************************
   // write decode
   // ****************************************************************
   assign wr_ctrl = wr_en_i && hit(addr_i, `OTGPC_CTRL_ADDR);
   assign wr_clr  = wr_en_i && hit(addr_i, `OTGPC_INT_CLR_ADDR);
   assign wr_en   = wr_en_i && hit(addr_i, `OTGPC_INT_EN_ADDR);

   // ****************************************************************
   // control register
   // ****************************************************************
   // read-only and reserved positions are masked off on write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = wr_data_i & `OTGPC_CTRL_RW_MASK;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= `OTGPC_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ****************************************************************
   // analogue helper controls
   // ****************************************************************
   assign vbus_pullup_en_o = ctrl_r[`OTGPC_VBUS_PU_BIT];
   assign rx_pwrdn_o       = ctrl_r[`OTGPC_RX_DIS_BIT];
   assign chg_pump_en_o    = ctrl_r[`OTGPC_CHG_PUMP_BIT];
   assign vbus_dischg_en_o = ctrl_r[`OTGPC_VBUS_DIS_BIT];
   assign dp_pullup_en_o   = ctrl_r[`OTGPC_DP_PU_BIT];
   assign dm_pullup_en_o   = ctrl_r[`OTGPC_DM_PU_BIT];
   assign dp_pulldown_en_o = ctrl_r[`OTGPC_DP_PD_BIT];
   assign dm_pulldown_en_o = ctrl_r[`OTGPC_DM_PD_BIT];

   // ****************************************************************
   // read data
   // ****************************************************************
   // data stand only in the cycle after the read strobe
   always_comb begin
      rd_data_nxt = 16'h0000;
      if (rd_en_i) begin
         rd_data_nxt = read_mux(addr_i, ctrl_r, pins_s, int_sts_r, int_en_r);
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_r <= 16'h0000;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_o = rd_data_r;

   // ****************************************************************
   // pin change detection
   // ****************************************************************
   // changes are ignored until the synchroniser has filled after reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prime_cnt_r <= 2'h0;
      end else if (prime_cnt_r != `OTGPC_PRIME_CYCLES) begin
         prime_cnt_r <= prime_cnt_r + 2'h1;
      end
   end

   assign primed = (prime_cnt_r == `OTGPC_PRIME_CYCLES);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pins_prev_r <= 3'h0;
      end else begin
         pins_prev_r <= pins_s;
      end
   end

   // ****************************************************************
   // vbus settle timer
   // ****************************************************************
   // flags the earliest moment the valid bit may be trusted after pump on
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pump_prev_r <= 1'b0;
      end else begin
         pump_prev_r <= ctrl_r[`OTGPC_CHG_PUMP_BIT];
      end
   end

   assign pump_rise = ctrl_r[`OTGPC_CHG_PUMP_BIT] && !pump_prev_r;

   always_comb begin
      settle_nxt = settle_r;
      settle_evt = 1'b0;
      unique case (settle_r)
         OTGPC_SETTLE_IDLE: begin
            if (pump_rise) begin
               settle_nxt = OTGPC_SETTLE_RUN;
            end
         end
         OTGPC_SETTLE_RUN: begin
            if (!ctrl_r[`OTGPC_CHG_PUMP_BIT]) begin
               settle_nxt = OTGPC_SETTLE_IDLE;
            end else if (settle_cnt_r == SETTLE_LAST) begin
               settle_nxt = OTGPC_SETTLE_DONE;
               settle_evt = 1'b1;
            end
         end
         OTGPC_SETTLE_DONE: begin
            if (!ctrl_r[`OTGPC_CHG_PUMP_BIT]) begin
               settle_nxt = OTGPC_SETTLE_IDLE;
            end
         end
         default: begin
            settle_nxt = OTGPC_SETTLE_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_r <= OTGPC_SETTLE_IDLE;
      end else begin
         settle_r <= settle_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_cnt_r <= 16'h0000;
      end else if (settle_r == OTGPC_SETTLE_RUN) begin
         settle_cnt_r <= settle_cnt_r + 16'h0001;
      end else begin
         settle_cnt_r <= 16'h0000;
      end
   end

   // ****************************************************************
   // interrupt status, clear and enable
   // ****************************************************************
   always_comb begin
      evt = 4'h0;
      if (primed) begin
         evt[`OTGPC_EVT_VBUS_LVL] = pins_s[`OTGPC_VBUS_LVL_BIT] ^ pins_prev_r[`OTGPC_VBUS_LVL_BIT];
         evt[`OTGPC_EVT_ID]       = pins_s[`OTGPC_ID_BIT] ^ pins_prev_r[`OTGPC_ID_BIT];
         evt[`OTGPC_EVT_VBUS_VLD] = pins_s[`OTGPC_VBUS_VLD_BIT] ^ pins_prev_r[`OTGPC_VBUS_VLD_BIT];
      end
      evt[`OTGPC_EVT_SETTLE] = settle_evt;
   end

   assign int_clr = wr_clr ? wr_data_i[3:0] : 4'h0;

   // a new event wins over a clear in the same cycle
   always_comb begin
      int_sts_nxt = (int_sts_r & ~int_clr) | evt;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_sts_r <= `OTGPC_INT_STS_RESET;
      end else begin
         int_sts_r <= int_sts_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_en_r <= `OTGPC_INT_EN_RESET;
      end else if (wr_en) begin
         int_en_r <= wr_data_i[3:0];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(int_sts_r & int_en_r);
      end
   end

   assign irq_o = irq_r;

endmodule : otgpc_top

// [otgpc_top_asserts.sv]
// assertion checker for the otg port control block
`timescale 1ns/1ps
`include "otgpc_regs.svh"

module otgpc_top_asserts #(
   parameter int unsigned SETTLE_CYCLES = 8
) (
   input wire logic                   ref_clk_i,
   input wire logic                   rst_i,
   input wire otgpc_pkg::otgpc_addr_t addr_i,
   input wire otgpc_pkg::otgpc_word_t wr_data_i,
   input wire logic                   wr_en_i,
   input wire logic                   rd_en_i,
   input wire otgpc_pkg::otgpc_word_t rd_data_o,
   input wire logic                   vbus_level_i,
   input wire logic                   id_pin_i,
   input wire logic                   vbus_valid_i,
   input wire logic                   vbus_pullup_en_o,
   input wire logic                   rx_pwrdn_o,
   input wire logic                   chg_pump_en_o,
   input wire logic                   vbus_dischg_en_o,
   input wire logic                   dp_pullup_en_o,
   input wire logic                   dm_pullup_en_o,
   input wire logic                   dp_pulldown_en_o,
   input wire logic                   dm_pulldown_en_o,
   input wire logic                   irq_o
);
   import otgpc_pkg::*;
   // ****************************************************************
   // helper logic
   // ****************************************************************
   logic [7:0] ctl;
   logic [3:0] en_r;
   logic [2:0] age_r;
   logic       wc;
   logic       rc;
   logic       zr;
   assign ctl = {vbus_pullup_en_o, rx_pwrdn_o, chg_pump_en_o, vbus_dischg_en_o,
                 dp_pullup_en_o, dm_pullup_en_o, dp_pulldown_en_o, dm_pulldown_en_o};
   assign wc = wr_en_i && addr_i == `OTGPC_CTRL_ADDR;
   assign rc = rd_en_i && addr_i == `OTGPC_CTRL_ADDR;
   assign zr = !rd_en_i || !(addr_i inside {`OTGPC_CTRL_ADDR, `OTGPC_INT_STS_ADDR,
                                           `OTGPC_INT_EN_ADDR});
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_r <= 4'h0;
      end else if (wr_en_i && addr_i == `OTGPC_INT_EN_ADDR) begin
         en_r <= wr_data_i[3:0];
      end
   end
   // pins are only trusted once the synchroniser has refilled
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
         age_r <= age_r + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // ****************************************************************
   // properties
   // ****************************************************************
   sequence s_en_off;
      (en_r == 4'h0) [*2];
   endsequence
   property p_ctrl_wr;
      wc |=> ctl == $past(wr_data_i[13:6]);
   endproperty
   property p_ctrl_hold;
      !wc |=> $stable(ctl);
   endproperty
   property p_rd_ctrl;
      rc && age_r == 3'h7 |=> rd_data_o == {2'h0, $past(ctl), 3'h0,
         $past({vbus_level_i, id_pin_i, vbus_valid_i}, 3)};
   endproperty
   property p_rd_zero;
      zr |=> rd_data_o == 16'h0;
   endproperty
   property p_sts_rd;
      rd_en_i && addr_i == `OTGPC_INT_STS_ADDR |=> rd_data_o[15:4] == 12'h0;
   endproperty
   property p_en_rd;
      rd_en_i && addr_i == `OTGPC_INT_EN_ADDR |=> rd_data_o == {12'h0, $past(en_r)};
   endproperty
   property p_irq_off;
      s_en_off |=> !irq_o;
   endproperty
   property p_rst;
      $fell(rst_i) |-> ctl == 8'h0 && !irq_o && rd_data_o == 16'h0;
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr)
      else $error("control outputs differ from written bits");
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control outputs changed without a write");
   a_rd_ctrl: assert property (p_rd_ctrl)
      else $error("control read data wrong");
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data not zero");
   a_sts_rd: assert property (p_sts_rd)
      else $error("status upper bits not zero");
   a_en_rd: assert property (p_en_rd)
      else $error("enable read data wrong");
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt high while all masked");
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
endmodule : otgpc_top_asserts

bind otgpc_top otgpc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_otgpc_top_asserts (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
   .vbus_level_i(vbus_level_i), .id_pin_i(id_pin_i), .vbus_valid_i(vbus_valid_i),
   .vbus_pullup_en_o(vbus_pullup_en_o), .rx_pwrdn_o(rx_pwrdn_o),
   .chg_pump_en_o(chg_pump_en_o), .vbus_dischg_en_o(vbus_dischg_en_o),
   .dp_pullup_en_o(dp_pullup_en_o), .dm_pullup_en_o(dm_pullup_en_o),
   .dp_pulldown_en_o(dp_pulldown_en_o), .dm_pulldown_en_o(dm_pulldown_en_o),
   .irq_o(irq_o));

// [otgpc_cable_model.sv]
// cable, vbus supply and id pin model facing the otg port
`timescale 1ns/1ps

module otgpc_cable_model #(
   parameter int unsigned RISE = 3
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic chg_pump_en_i,
   input  wire logic vbus_dischg_en_i,
   input  wire logic id_gnd_i,
   output logic      vbus_level_o,
   output logic      id_pin_o,
   output logic      vbus_valid_o
);
   logic [3:0] lvl_r;
   // vbus ramps only while the pump runs and no discharge load is on
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i || !chg_pump_en_i || vbus_dischg_en_i) begin
         lvl_r <= 4'h0;
      end else if (lvl_r != 4'hf) begin
         lvl_r <= lvl_r + 4'h1;
      end
   end
   assign vbus_level_o = {28'h0, lvl_r} >= RISE;
   assign vbus_valid_o = {28'h0, lvl_r} >= 2 * RISE;
   assign id_pin_o = !id_gnd_i;
endmodule : otgpc_cable_model

// [otgpc_top_test.sv]
// self-checking testbench of the otg port control block
`timescale 1ns/1ps
`include "otgpc_regs.svh"

module otgpc_top_test;
   import otgpc_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   otgpc_addr_t addr_i = 16'h0;
   otgpc_word_t wr_data_i = 16'h0;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic        id_gnd = 1'b0;
   otgpc_word_t rd_data_o;
   logic        vl;
   logic        idp;
   logic        vv;
   logic        irq_o;
   logic [7:0]  ctl;
   logic [7:0]  ctl_exp = 8'h0;
   otgpc_word_t exp_q[$];
   logic [7:0]  ctl_q[$];
   logic        rd_vld_r = 1'b0;
   logic        wc_vld_r = 1'b0;
   logic        irq_s = 1'b0;
   int          err_total = 0;
   int          check_count = 0;
   logic [31:0] seed = 32'h2c26ae32;

   always #2 ref_clk_i = ~ref_clk_i;

   otgpc_top #(.SETTLE_CYCLES(8)) i_otgpc_top (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .vbus_level_i(vl), .id_pin_i(idp), .vbus_valid_i(vv),
      .vbus_pullup_en_o(ctl[7]), .rx_pwrdn_o(ctl[6]), .chg_pump_en_o(ctl[5]),
      .vbus_dischg_en_o(ctl[4]), .dp_pullup_en_o(ctl[3]), .dm_pullup_en_o(ctl[2]),
      .dp_pulldown_en_o(ctl[1]), .dm_pulldown_en_o(ctl[0]), .irq_o(irq_o));

   otgpc_cable_model i_otgpc_cable_model (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .chg_pump_en_i(ctl[5]),
      .vbus_dischg_en_i(ctl[4]), .id_gnd_i(id_gnd), .vbus_level_o(vl),
      .id_pin_o(idp), .vbus_valid_o(vv));

   // ****************************************************************
   // tasks
   // ****************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   function automatic otgpc_word_t ectl();
      return {2'h0, ctl_exp, 3'h0, vl, idp, vv};
   endfunction : ectl

   task automatic cmp(input otgpc_word_t got, input otgpc_word_t exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic complete_run;
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic bus(input logic w, input logic r, input otgpc_addr_t a, input otgpc_word_t d);
      wr_en_i <= w;
      rd_en_i <= r;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge ref_clk_i);
   endtask : bus

   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 16'h0, 16'h0);
   endtask : idle

   task automatic wr(input otgpc_addr_t a, input otgpc_word_t d);
      if (a == `OTGPC_CTRL_ADDR) begin
         ctl_exp = d[13:6];
         ctl_q.push_back(d[13:6]);
      end
      bus(1'b1, 1'b0, a, d);
   endtask : wr

   task automatic rd(input otgpc_addr_t a, input otgpc_word_t e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 16'h0);
   endtask : rd

   task automatic wait_irq(input logic lvl);
      for (int n = 0; n < 10 && irq_s !== lvl; n++) idle(1);
      cmp({15'h0, irq_s}, {15'h0, lvl});
   endtask : wait_irq

   // ****************************************************************
   // result monitor
   // ****************************************************************
   always @(posedge ref_clk_i) begin
      rd_vld_r <= rd_en_i;
      wc_vld_r <= wr_en_i && addr_i == `OTGPC_CTRL_ADDR;
   end
   // interrupt level is taken mid-cycle, where it has settled
   always @(negedge ref_clk_i) begin
      irq_s <= irq_o;
      if (rd_vld_r && exp_q.size() > 0) cmp(rd_data_o, exp_q.pop_front());
      if (wc_vld_r && ctl_q.size() > 0) cmp({8'h0, ctl}, {8'h0, ctl_q.pop_front()});
   end

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      err_total++;
      complete_run();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      idle(6);
      rd(`OTGPC_CTRL_ADDR, ectl());
      for (int i = 6; i < 14; i++) begin
         wr(`OTGPC_CTRL_ADDR, 16'h1 << i);
         rd(`OTGPC_CTRL_ADDR, ectl());
      end
      repeat (4) begin
         seed = xs(seed);
         wr(`OTGPC_CTRL_ADDR, seed[15:0] & 16'h37c0);
         rd(`OTGPC_CTRL_ADDR, ectl());
      end
      wr(`OTGPC_CTRL_ADDR, 16'h3fc7);
      rd(`OTGPC_CTRL_ADDR, ectl());
      wr(`OTGPC_CTRL_ADDR, 16'h0);
      rd(16'hc0a0, 16'h0);
      rd(`OTGPC_INT_CLR_ADDR, 16'h0);
      idle(8);
      wr(`OTGPC_INT_CLR_ADDR, 16'hf);
      wr(`OTGPC_INT_EN_ADDR, 16'h2);
      rd(`OTGPC_INT_EN_ADDR, 16'h2);
      id_gnd <= 1'b1;
      wait_irq(1'b1);
      wr(`OTGPC_INT_STS_ADDR, 16'h0);
      rd(`OTGPC_INT_STS_ADDR, 16'h2);
      rd(`OTGPC_CTRL_ADDR, ectl());
      wr(`OTGPC_INT_EN_ADDR, 16'h0);
      wait_irq(1'b0);
      wr(`OTGPC_INT_EN_ADDR, 16'h2);
      wait_irq(1'b1);
      wr(`OTGPC_INT_CLR_ADDR, 16'h2);
      wait_irq(1'b0);
      rd(`OTGPC_INT_STS_ADDR, 16'h0);
      wr(`OTGPC_CTRL_ADDR, 16'h0800);
      idle(20);
      rd(`OTGPC_CTRL_ADDR, ectl());
      rd(`OTGPC_INT_STS_ADDR, 16'hd);
      wr(`OTGPC_CTRL_ADDR, 16'h0400);
      idle(8);
      rd(`OTGPC_CTRL_ADDR, ectl());
      wr(`OTGPC_CTRL_ADDR, 16'h3fc0);
      idle(1);
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      ctl_exp = 8'h0;
      idle(6);
      rd(`OTGPC_CTRL_ADDR, ectl());
      idle(2);
      complete_run();
   end
endmodule : otgpc_top_test
